// >>> src/trx_regs.svh
// Register offsets, field positions, masks and reset values of the receive-init and power register bank.
`ifndef TRX_REGS_SVH
`define TRX_REGS_SVH

`define TRX_OFS_RX_INIT_CONTROL    8'h24
`define TRX_OFS_RX_INIT_STATUS     8'h28
`define TRX_OFS_REFCLK_GATE        8'h2c
`define TRX_OFS_POWER_DOWN         8'h30
`define TRX_OFS_IRQ_STATUS         8'h34
`define TRX_OFS_IRQ_MASK           8'h3c
`define TRX_OFS_CONFIG             8'h60

`define TRX_RXI_FULL_RESET         0
`define TRX_RXI_PMA_RESET          1
`define TRX_RXI_EQ_RESET           2
`define TRX_RXI_RESERVED           3
`define TRX_RXI_PCS_RESET          4
`define TRX_RXI_BUF_RESET          5
`define TRX_RXI_USER_READY         6
`define TRX_RXI_PLL_AND_TRANSCEIVER_RESET       7

`define TRX_RXS_RESET_DONE         0
`define TRX_RXS_PMA_DONE           1
`define TRX_RXS_POWER_GOOD         2

`define TRX_PDC_CPLL               0
`define TRX_PDC_QPLL0              1
`define TRX_PDC_QPLL1              2
`define TRX_PDC_RX_LO              3
`define TRX_PDC_TX_LO              5

`define TRX_PDC_CH1_MASK           8'h7f
`define TRX_PDC_CHN_MASK           8'h79
`define TRX_REFCLK_MASK            32'h0000_0003

`define TRX_RESET_WORD             32'h0000_0000
`define TRX_UNMAPPED_READ          32'h0000_0000

`define TRX_CFG_DP                 0
`define TRX_CFG_FAMILY_LO          1

`endif

// >>> src/trx_pkg.sv
// Types shared by the receive-init and power register bank.
package trx_pkg;

	typedef enum logic [1:0]
	{
		TRX_FAM_OLDER  = 2'b00,
		TRX_FAM_NEWER  = 2'b01,
		TRX_FAM_LOWEST = 2'b10
	} trx_family_e;

	typedef struct packed
	{
		logic [31:0] rx_init_control;
		logic [1:0]  refclk_gate;
		logic [31:0] power_down;
		logic        dp_mode;
		logic [1:0]  family;
		logic [3:0]  irq_status;
		logic [3:0]  irq_mask;
		logic [3:0]  rx_done_prev;
		logic [3:0]  pg_prev;
		logic [31:0] rd_data;
	} trx_state_s;

endpackage

// >>> src/trx_rx_init_power_regs.sv
// Receive-init, reference clock gate and power-down register bank for four transceiver channels.
// How it works
// [RL1] Each channel owns one read-write byte of rx-init control, all zero after reset.
// [RL2] In DisplayPort mode the equalizer reset bit never reaches the transceiver.
// [RL3] DisplayPort on the newer family: PCS reset and user-ready unused; internal FSM drives ready.
// [RL4] Read-only rx status byte per channel: reset done, PMA done, power good.
// [RL5] DisplayPort on the older and lowest-cost families reads PMA reset done as constant one.
// [RL6] Rx power-good status uses the same signal as the tx status power-good bit.
// [RL7] Bits 0 and 1 drive the active-low enables of reference clock buffers.
// [RL8] Channel 1 power byte: channel PLL, quad PLL0, quad PLL1, rx and tx power-down.
// [RL9] Channels 2 to 4 hold only channel PLL, rx and tx power-down fields.
// [RL10] Quad PLL1 power-down drives the second PLL on newer and lowest-cost families.
// [RL11] Channel PLL power-down bits act only on the older family.
// [RL12] Reserved bits read zero, except rx-init control bit 3, which reads back; writes to them affect no control output.
`timescale 1ns/1ps
`include "trx_regs.svh"

module trx_rx_init_power_regs
	import trx_pkg::*;
#(
	parameter int NUM_CH = 4
)
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	output logic                     irq,
	output logic      [NUM_CH-1:0]   rx_full_reset,
	output logic      [NUM_CH-1:0]   rx_pma_reset_a,
	output logic      [NUM_CH-1:0]   rx_equalizer_reset,
	output logic      [NUM_CH-1:0]   rx_pcs_reset_b,
	output logic      [NUM_CH-1:0]   rx_elastic_buffer_reset,
	output logic      [NUM_CH-1:0]   rx_user_ready,
	output logic      [NUM_CH-1:0]   pll_and_transceiver_reset,
	input  wire logic [NUM_CH-1:0]   rx_reset_complete,
	input  wire logic [NUM_CH-1:0]   rx_pma_reset_complete,
	input  wire logic [NUM_CH-1:0]   transceiver_power_good,
	input  wire logic [NUM_CH-1:0]   fsm_rx_user_ready,
	output logic                     refclk0_buffer_disable,
	output logic                     refclk1_buffer_disable,
	output logic      [NUM_CH-1:0]   channel_pll_power_down,
	output logic                     quad_pll0_power_down,
	output logic                     quad_pll1_power_down,
	output logic      [2*NUM_CH-1:0] rx_power_down,
	output logic      [2*NUM_CH-1:0] tx_power_down
);

	trx_state_s st_ff;
	trx_state_s nxt_st;

	// Status pins come from the transceiver clock domains, so each passes four flops, the last updating only when two stages agree.
	logic [NUM_CH-1:0] sync1_ff [3];
	logic [NUM_CH-1:0] sync2_ff [3];
	logic [NUM_CH-1:0] sync3_ff [3];
	logic [NUM_CH-1:0] stat_ff  [3];
	logic [NUM_CH-1:0] raw_in   [3];

	assign raw_in[0] = rx_reset_complete;
	assign raw_in[1] = rx_pma_reset_complete;
	assign raw_in[2] = transceiver_power_good;

	always_ff @(posedge clk)
	begin
		for (int k = 0; k < 3; k++)
		begin
			if (!rst_n)
			begin
				sync1_ff[k] <= '0;
				sync2_ff[k] <= '0;
				sync3_ff[k] <= '0;
				stat_ff[k]  <= '0;
			end
			else
			begin
				sync1_ff[k] <= raw_in[k];
				sync2_ff[k] <= sync1_ff[k];
				sync3_ff[k] <= sync2_ff[k];
				for (int c = 0; c < NUM_CH; c++)
				begin
					if (sync2_ff[k][c] == sync3_ff[k][c])
					begin
						stat_ff[k][c] <= sync3_ff[k][c];
					end
				end
			end
		end
	end

	logic        older;
	logic        dp_newer;
	logic [31:0] status_word;
	logic [31:0] pdc_wmask;
	logic [3:0]  events;

	assign older    = (st_ff.family == TRX_FAM_OLDER);
	// The lowest-cost family belongs to the older generation, so only the newer family hands control to the FSM.
	assign dp_newer = st_ff.dp_mode && (st_ff.family == TRX_FAM_NEWER);

	always_comb
	begin
		status_word = `TRX_RESET_WORD;
		for (int c = 0; c < NUM_CH; c++)
		begin
			status_word[8*c+`TRX_RXS_RESET_DONE] = stat_ff[0][c]; // RL4
			status_word[8*c+`TRX_RXS_PMA_DONE]   = (st_ff.dp_mode && !dp_newer) ? 1'b1 : stat_ff[1][c]; // RL5
			status_word[8*c+`TRX_RXS_POWER_GOOD] = stat_ff[2][c]; // RL6
		end
	end

	always_comb
	begin
		pdc_wmask = {`TRX_PDC_CHN_MASK, `TRX_PDC_CHN_MASK, `TRX_PDC_CHN_MASK, `TRX_PDC_CH1_MASK}; // RL8 RL9 RL12
	end

	// Events: a channel's rx reset done or power good rising.
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			events[c] = (c < NUM_CH) && ((stat_ff[0][c] && !st_ff.rx_done_prev[c])
				|| (stat_ff[2][c] && !st_ff.pg_prev[c]));
		end
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rd_data = `TRX_UNMAPPED_READ;
		for (int c = 0; c < NUM_CH; c++)
		begin
			nxt_st.rx_done_prev[c] = stat_ff[0][c];
			nxt_st.pg_prev[c]      = stat_ff[2][c];
		end
		if (reg_wr)
		begin
			case (reg_addr)
				`TRX_OFS_RX_INIT_CONTROL: nxt_st.rx_init_control = reg_wdata; // RL1
				`TRX_OFS_REFCLK_GATE:     nxt_st.refclk_gate     = reg_wdata[1:0]; // RL7
				`TRX_OFS_POWER_DOWN:      nxt_st.power_down      = reg_wdata & pdc_wmask; // RL12
				`TRX_OFS_IRQ_STATUS:      nxt_st.irq_status      = st_ff.irq_status & ~reg_wdata[3:0];
				`TRX_OFS_IRQ_MASK:        nxt_st.irq_mask        = reg_wdata[3:0];
				`TRX_OFS_CONFIG:
				begin
					nxt_st.dp_mode = reg_wdata[`TRX_CFG_DP];
					nxt_st.family  = reg_wdata[`TRX_CFG_FAMILY_LO+1:`TRX_CFG_FAMILY_LO];
				end
				default: ;
			endcase
		end
		// Set is applied after the clear so an event in the clear cycle is kept.
		nxt_st.irq_status = nxt_st.irq_status | events;
		if (reg_rd)
		begin
			case (reg_addr)
				`TRX_OFS_RX_INIT_CONTROL: nxt_st.rd_data = st_ff.rx_init_control;
				`TRX_OFS_RX_INIT_STATUS:  nxt_st.rd_data = status_word; // RL4
				`TRX_OFS_REFCLK_GATE:     nxt_st.rd_data = {30'h0000_0000, st_ff.refclk_gate};
				`TRX_OFS_POWER_DOWN:      nxt_st.rd_data = st_ff.power_down; // RL12
				`TRX_OFS_IRQ_STATUS:      nxt_st.rd_data = {28'h000_0000, st_ff.irq_status};
				`TRX_OFS_IRQ_MASK:        nxt_st.rd_data = {28'h000_0000, st_ff.irq_mask};
				`TRX_OFS_CONFIG:          nxt_st.rd_data = {29'h0000_0000, st_ff.family, st_ff.dp_mode};
				default:                  nxt_st.rd_data = `TRX_UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rd_data;
	assign irq       = |(st_ff.irq_status & st_ff.irq_mask);

	// Unused fields are forced inactive, or handed to the FSM for user-ready, rather than hidden from software, so readback stays honest.
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			rx_full_reset[c]             = st_ff.rx_init_control[8*c+`TRX_RXI_FULL_RESET]; // RL1
			rx_pma_reset_a[c]            = st_ff.rx_init_control[8*c+`TRX_RXI_PMA_RESET];
			rx_equalizer_reset[c]        = !st_ff.dp_mode && st_ff.rx_init_control[8*c+`TRX_RXI_EQ_RESET]; // RL2
			rx_pcs_reset_b[c]            = !dp_newer && st_ff.rx_init_control[8*c+`TRX_RXI_PCS_RESET]; // RL3
			rx_elastic_buffer_reset[c]   = st_ff.rx_init_control[8*c+`TRX_RXI_BUF_RESET];
			rx_user_ready[c]             = dp_newer ? fsm_rx_user_ready[c]
				: st_ff.rx_init_control[8*c+`TRX_RXI_USER_READY]; // RL3
			pll_and_transceiver_reset[c] = st_ff.rx_init_control[8*c+`TRX_RXI_PLL_AND_TRANSCEIVER_RESET];
			channel_pll_power_down[c]    = older && st_ff.power_down[8*c+`TRX_PDC_CPLL]; // RL11
			rx_power_down[2*c+:2]        = st_ff.power_down[8*c+`TRX_PDC_RX_LO+:2]; // RL9
			tx_power_down[2*c+:2]        = st_ff.power_down[8*c+`TRX_PDC_TX_LO+:2]; // RL9
		end
	end

	assign refclk0_buffer_disable = st_ff.refclk_gate[0]; // RL7
	assign refclk1_buffer_disable = st_ff.refclk_gate[1]; // RL7
	assign quad_pll0_power_down   = st_ff.power_down[`TRX_PDC_QPLL0]; // RL8
	assign quad_pll1_power_down   = st_ff.power_down[`TRX_PDC_QPLL1]; // RL10

endmodule

// >>> verification/trx_asserts.sv
// Port checks for the receive-init and power register bank.
`timescale 1ns/1ps
module trx_asserts
	import trx_pkg::*;
#(
	parameter int NUM_CH = 4
)
(
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic [7:0]	reg_addr,
	input wire logic [31:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [31:0]	reg_rdata,
	input wire logic [NUM_CH-1:0]	rx_full_reset,
	input wire logic	refclk0_buffer_disable,
	input wire logic [2*NUM_CH-1:0]	rx_power_down,
	input wire logic [2*NUM_CH-1:0]	tx_power_down
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire	w30 = reg_wr && reg_addr == 8'h30;
	wire	r28 = reg_rd && reg_addr == 8'h28;
	wire	r40 = reg_rd && reg_addr == 8'h40;
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
	a_ctrl_wr: assert property (reg_wr && reg_addr == 8'h24 |=> rx_full_reset[0] == $past(reg_wdata[0]))
		else $error("full reset bit");
	a_stat_rsv: assert property (r28 |=> (reg_rdata & 32'hf8f8_f8f8) == 32'h0)
		else $error("status reserved bits");
	a_refclk_wr: assert property (reg_wr && reg_addr == 8'h2c |=> refclk0_buffer_disable == $past(reg_wdata[0]))
		else $error("refclk gate");
	a_pdc_rsv: assert property (reg_rd && reg_addr == 8'h30 |=> (reg_rdata & 32'h8686_8680) == 32'h0)
		else $error("power reserved bits");
	a_pdc_rx: assert property (w30 |=> rx_power_down[1:0] == $past(reg_wdata[4:3]))
		else $error("rx power down");
	a_pdc_tx: assert property (w30 |=> tx_power_down[7:6] == $past(reg_wdata[30:29]))
		else $error("tx power down");
	a_unmapped_rd: assert property (r40 |=> reg_rdata == 32'h0)
		else $error("unmapped read");
	c_pdc_wr: cover property (w30);
	c_stat_rd: cover property (r28);
	c_unmapped: cover property (r40);
endmodule

// >>> verification/trx_xcvr_model.sv
// Behavioural model of four transceiver channels returning status.
`timescale 1ns/1ps
module trx_xcvr_model
(
	input wire logic	clk,
	input wire logic	slow,
	input wire logic [3:0]	pg_on,
	input wire logic [3:0]	rx_full_reset,
	input wire logic [3:0]	rx_pma_reset_a,
	output logic [3:0]	rx_reset_complete,
	output logic [3:0]	rx_pma_reset_complete,
	output logic [3:0]	transceiver_power_good,
	output logic [3:0]	fsm_rx_user_ready
);
	logic [3:0]	d1;
	logic [3:0]	d2;
	// Slow mode adds a cycle so the status path is seen at two latencies.
	always_ff @(posedge clk)
	begin
		d1 <= pg_on & ~rx_full_reset;
		d2 <= d1;
	end
	assign rx_reset_complete = slow ? d2 : d1;
	assign rx_pma_reset_complete = rx_reset_complete & ~rx_pma_reset_a;
	assign transceiver_power_good = pg_on;
	assign fsm_rx_user_ready = rx_reset_complete;
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the receive-init and power register bank.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("mismatch at %0t: %h %h", $time, a, b); end end
module tb_top;
	logic	clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, slow = 0, rd_q = 0, dp, nw;
	logic [7:0]	reg_addr = 8'h00, rx_power_down, tx_power_down;
	logic [31:0]	reg_wdata = 32'h0, reg_rdata, w, q[$];
	logic [3:0]	pg_on = 4'h0, rx_full_reset, rx_pma_reset_a, rx_equalizer_reset, rx_pcs_reset_b, rx_elastic_buffer_reset;
	logic [3:0]	rx_user_ready, pll_and_transceiver_reset, rx_reset_complete, rx_pma_reset_complete;
	logic [3:0]	transceiver_power_good, fsm_rx_user_ready, channel_pll_power_down;
	logic	irq, refclk0_buffer_disable, refclk1_buffer_disable, quad_pll0_power_down, quad_pll1_power_down;
	logic [31:0]	cfg [4] = '{32'h0, 32'h1, 32'h3, 32'h5};
	int	n_errors = 0, n_compared = 0, cyc = 0, seed = 87;
	always #10 clk = ~clk;
	trx_rx_init_power_regs i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.rx_full_reset, .rx_pma_reset_a, .rx_equalizer_reset, .rx_pcs_reset_b, .rx_elastic_buffer_reset,
		.rx_user_ready, .pll_and_transceiver_reset, .rx_reset_complete, .rx_pma_reset_complete,
		.transceiver_power_good, .fsm_rx_user_ready, .refclk0_buffer_disable, .refclk1_buffer_disable,
		.channel_pll_power_down, .quad_pll0_power_down, .quad_pll1_power_down, .rx_power_down, .tx_power_down);
	trx_xcvr_model i_xcvr (.clk, .slow, .pg_on, .rx_full_reset, .rx_pma_reset_a, .rx_reset_complete,
		.rx_pma_reset_complete, .transceiver_power_good, .fsm_rx_user_ready);
	function automatic logic [3:0] sel(input logic [31:0] v, input int b);
		return {v[24+b], v[16+b], v[8+b], v[b]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr <= 1;
		reg_rd <= 0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		reg_rd <= 1;
		reg_wr <= 0;
		reg_addr <= a;
		@(posedge clk);
	endtask
	task automatic nop(input int n);
		reg_wr <= 0;
		reg_rd <= 0;
		repeat (n) @(posedge clk);
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (rd_q) `CHK(reg_rdata, q.pop_front())
		rd_q <= reg_rd;
		if (cyc == 3000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		for (int a = 8'h24; a <= 8'h30; a += 4) rd(a[7:0], 32'h0);
		w = $random(seed);
		wr(8'h24, w);
		rd(8'h24, w);
		nop(1);
		`CHK({rx_full_reset, rx_pma_reset_a, rx_elastic_buffer_reset}, {sel(w, 0), sel(w, 1), sel(w, 5)});
		`CHK({rx_equalizer_reset, pll_and_transceiver_reset}, {sel(w, 2), sel(w, 7)});
		pg_on <= 4'hf;
		slow <= 1;
		wr(8'h24, 32'h1616_1616);
		foreach (cfg[i])
		begin
			wr(8'h60, cfg[i]);
			nop(8);
			dp = cfg[i][0];
			nw = dp && cfg[i][2:1] == 2'b01;
			rd(8'h28, dp && !nw ? 32'h0707_0707 : 32'h0505_0505);
			nop(1);
			`CHK(rx_equalizer_reset, dp ? 4'h0 : 4'hf);
			`CHK({rx_pcs_reset_b, rx_user_ready}, nw ? {4'h0, fsm_rx_user_ready} : 8'hf0);
		end
		wr(8'h2c, 32'h0000_0001);
		rd(8'h2c, 32'h0000_0001);
		nop(1);
		`CHK({refclk1_buffer_disable, refclk0_buffer_disable}, 2'b01);
		w = $random(seed);
		wr(8'h30, w);
		rd(8'h30, w & 32'h7979_797f);
		nop(1);
		`CHK({quad_pll1_power_down, quad_pll0_power_down}, w[2:1]);
		`CHK(rx_power_down, {w[28:27], w[20:19], w[12:11], w[4:3]});
		`CHK(tx_power_down, {w[30:29], w[22:21], w[14:13], w[6:5]});
		`CHK(channel_pll_power_down, 4'h0);
		wr(8'h60, 32'h0);
		nop(1);
		`CHK(channel_pll_power_down, sel(w, 0));
		`CHK(irq, 1'b0);
		wr(8'h34, 32'h0000_000f);
		wr(8'h3c, 32'h0000_0001);
		pg_on <= 4'he;
		nop(8);
		pg_on <= 4'hf;
		nop(8);
		`CHK(irq, 1'b1);
		rd(8'h34, 32'h0000_0001);
		wr(8'h34, 32'h0000_0001);
		nop(1);
		`CHK(irq, 1'b0);
		rd(8'h40, 32'h0);
		wr(8'h28, 32'hffff_ffff);
		rd(8'h28, 32'h0505_0505);
		nop(2);
		wrap_up();
	end
endmodule
bind trx_rx_init_power_regs trx_asserts #(.NUM_CH(NUM_CH)) u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .rx_full_reset, .refclk0_buffer_disable, .rx_power_down, .tx_power_down);
